// *** rtl/tmrcc_cfg.svh ***
// Purpose: constants of the timer control and count block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: register fields sit in the low 16 bits; upper bits read zero
`ifndef TMRCC_CFG_SVH
`define TMRCC_CFG_SVH

// ========================================
// register offsets
`define TMRCC_OFS_CTRL 8'h00
`define TMRCC_OFS_COUNT 8'h04
`define TMRCC_OFS_STATUS 8'h08
`define TMRCC_OFS_MASK 8'h0C
`define TMRCC_OFS_VECTOR 8'h10

// ========================================
// control fields
`define TMRCC_F_GRP 14:13
`define TMRCC_F_LEN 12:11
`define TMRCC_F_SRC 9:8
`define TMRCC_F_DIV 7:6
`define TMRCC_F_MODE 5:4
`define TMRCC_B_CLR 2
`define TMRCC_B_IE 1
`define TMRCC_B_FLAG 0

// ========================================
// values
`define TMRCC_MAX16 16'hFFFF
`define TMRCC_MAX12 16'h0FFF
`define TMRCC_MAX10 16'h03FF
`define TMRCC_DIVM1 3'h0
`define TMRCC_DIVM2 3'h1
`define TMRCC_DIVM4 3'h3
`define TMRCC_DIVM8 3'h7
`define TMRCC_VEC_OVF 16'h000E
`define TMRCC_VEC_NONE 16'h0000
`define TMRCC_ST_OVF 0

`endif

// *** rtl/tmrcc_pkg.sv ***
// Purpose: types of the timer control and count block
// Assumes: constants come from tmrcc_cfg.svh
// Notes: none
package tmrcc_pkg;

	typedef enum logic [1:0] {TMRCC_STOP, TMRCC_UP, TMRCC_CONT, TMRCC_UPDN} tmrcc_mode_t;
	typedef enum logic [1:0] {TMRCC_SRC_EXT, TMRCC_SRC_AUX, TMRCC_SRC_SUB, TMRCC_SRC_INV} tmrcc_src_t;
	typedef enum logic [1:0] {TMRCC_GRP_NONE, TMRCC_GRP_PAIR, TMRCC_GRP_TRIPLE, TMRCC_GRP_ALL} tmrcc_grp_t;

	typedef struct packed {
		tmrcc_grp_t latchGrouping;
		logic [1:0] counterLength;
		tmrcc_src_t clockSourceSelect;
		logic [1:0] prescaleDivider;
		tmrcc_mode_t countMode;
		logic overflowIrqEnable;
		logic overflowIrqFlag;
		logic [15:0] count;
		logic countDown;
		logic [2:0] divCount;
		logic prevExt;
		logic prevAux;
		logic prevSub;
		logic [0:0] status;
		logic [0:0] mask;
		logic [0:0] statusCaught;
		logic [31:0] readData;
		logic [6:0] latchUpdate;
	} tmrcc_state_t;

endpackage

// *** rtl/tmrcc_top.sv ***
// Purpose: timer control and count core with APB register access
// Assumes: clock source inputs are synchronous levels on clk_sys
// Notes: read data is captured in the setup cycle, pready rises in the access cycle
`include "tmrcc_cfg.svh"

module tmrcc_top
	import tmrcc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic externalTimerClock,
	input wire logic auxClock,
	input wire logic subMainClock,
	input wire logic [15:0] periodLatch,
	input wire logic [6:0] latchLoadEvent,
	output logic [6:0] compareLatchUpdate,
	output logic [15:0] countValue,
	output logic [1:0] countMode,
	output logic countDown,
	output logic overflowIrqRequest,
	output logic [15:0] interruptVector,
	output logic irq
);

	// ========================================
	// reset release
	logic rstMeta;
	logic rstSync;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// ========================================
	// state
	tmrcc_state_t st;
	tmrcc_state_t next_st;

	logic setupRd;
	logic accessWr;
	logic accessRd;
	logic mapped;
	logic writable;
	logic srcEdge;
	logic tick;
	logic overflow;
	logic [2:0] divMask;
	logic [15:0] lenMax;
	logic [15:0] ctrlView;
	logic [15:0] vectorView;

	assign setupRd = psel && !penable && !pwrite;
	assign accessWr = psel && penable && pwrite && writable;
	assign accessRd = psel && penable && !pwrite;
	assign pready = psel && penable;
	assign pslverr = psel && penable && (pwrite ? !writable : !mapped);

	always_comb begin
		unique case (paddr)
			`TMRCC_OFS_CTRL, `TMRCC_OFS_COUNT, `TMRCC_OFS_STATUS, `TMRCC_OFS_MASK: begin
				mapped = 1'b1;
				writable = 1'b1;
			end
			`TMRCC_OFS_VECTOR: begin
				mapped = 1'b1;
				writable = 1'b0;
			end
			default: begin
				mapped = 1'b0;
				writable = 1'b0;
			end
		endcase
	end

	// ========================================
	// compare latch grouping, latches of a group share one source channel
	logic [6:0] groupedEvent;

	for (genvar i = 0; i < 7; i++) begin : g_latch
		localparam int PAIR_SRC = (i == 0) ? 0 : ((i % 2 == 1) ? i : i - 1);
		localparam int TRIPLE_SRC = (i == 0) ? 0 : ((i <= 3) ? 1 : 4);
		assign groupedEvent[i] = (st.latchGrouping == TMRCC_GRP_PAIR) ? latchLoadEvent[PAIR_SRC]
			: (st.latchGrouping == TMRCC_GRP_TRIPLE) ? latchLoadEvent[TRIPLE_SRC]
			: (st.latchGrouping == TMRCC_GRP_ALL) ? latchLoadEvent[1]
			: latchLoadEvent[i];
	end

	// ========================================
	// combinational next state
	always_comb begin
		next_st = st;
		srcEdge = 1'b0;
		overflow = 1'b0;
		tick = 1'b0;
		divMask = `TMRCC_DIVM1;
		lenMax = `TMRCC_MAX16;
		ctrlView = 16'h0000;
		vectorView = `TMRCC_VEC_NONE;

		next_st.prevExt = externalTimerClock;
		next_st.prevAux = auxClock;
		next_st.prevSub = subMainClock;

		// source edge select
		unique case (st.clockSourceSelect)
			TMRCC_SRC_EXT: srcEdge = externalTimerClock && !st.prevExt;
			TMRCC_SRC_AUX: srcEdge = auxClock && !st.prevAux;
			TMRCC_SRC_SUB: srcEdge = subMainClock && !st.prevSub;
			TMRCC_SRC_INV: srcEdge = !externalTimerClock && st.prevExt;
		endcase

		// prescaler
		unique case (st.prescaleDivider)
			2'b00: divMask = `TMRCC_DIVM1;
			2'b01: divMask = `TMRCC_DIVM2;
			2'b10: divMask = `TMRCC_DIVM4;
			2'b11: divMask = `TMRCC_DIVM8;
		endcase
		if (srcEdge && st.countMode != TMRCC_STOP) begin
			if (st.divCount >= divMask) begin
				next_st.divCount = 3'h0;
				tick = 1'b1;
			end else begin
				next_st.divCount = st.divCount + 3'h1;
			end
		end

		// counter length
		unique case (st.counterLength)
			2'b01: lenMax = `TMRCC_MAX12;
			2'b10: lenMax = `TMRCC_MAX10;
			default: lenMax = `TMRCC_MAX16;
		endcase

		// counting
		if (tick) begin
			unique case (st.countMode)
				TMRCC_STOP: next_st.count = st.count;
				TMRCC_UP: begin
					if (st.count >= periodLatch) begin
						next_st.count = 16'h0000;
						overflow = 1'b1;
					end else begin
						next_st.count = st.count + 16'h0001;
					end
				end
				TMRCC_CONT: begin
					if (st.count >= lenMax) begin
						next_st.count = 16'h0000;
						overflow = 1'b1;
					end else begin
						next_st.count = st.count + 16'h0001;
					end
				end
				TMRCC_UPDN: begin
					if (!st.countDown) begin
						if (st.count >= periodLatch) begin
							next_st.countDown = (periodLatch != 16'h0000);
							next_st.count = (periodLatch != 16'h0000) ? periodLatch - 16'h0001 : 16'h0000;
						end else begin
							next_st.count = st.count + 16'h0001;
						end
					end else if (st.count <= 16'h0001) begin
						next_st.count = 16'h0000;
						next_st.countDown = 1'b0;
						overflow = 1'b1;
					end else begin
						next_st.count = st.count - 16'h0001;
					end
				end
			endcase
		end

		// overflow flag, hardware set wins over software clear
		next_st.overflowIrqFlag = st.overflowIrqFlag || overflow;
		if (accessWr && paddr == `TMRCC_OFS_CTRL) begin
			next_st.latchGrouping = tmrcc_grp_t'(pwdata[`TMRCC_F_GRP]);
			next_st.counterLength = pwdata[`TMRCC_F_LEN];
			next_st.clockSourceSelect = tmrcc_src_t'(pwdata[`TMRCC_F_SRC]);
			next_st.prescaleDivider = pwdata[`TMRCC_F_DIV];
			next_st.countMode = tmrcc_mode_t'(pwdata[`TMRCC_F_MODE]);
			next_st.overflowIrqEnable = pwdata[`TMRCC_B_IE];
			next_st.overflowIrqFlag = pwdata[`TMRCC_B_FLAG] || overflow;
			if (pwdata[`TMRCC_B_CLR]) begin
				next_st.count = 16'h0000;
				next_st.prescaleDivider = 2'b00;
				next_st.divCount = 3'h0;
				next_st.countDown = 1'b0;
			end
		end
		if (accessWr && paddr == `TMRCC_OFS_COUNT) begin
			next_st.count = pwdata[15:0];
		end
		if (accessWr && paddr == `TMRCC_OFS_MASK) begin
			next_st.mask = pwdata[`TMRCC_ST_OVF];
		end

		// sticky status, cleared by read, new event wins
		next_st.status[`TMRCC_ST_OVF] = st.status[`TMRCC_ST_OVF] || overflow;
		if (accessRd && paddr == `TMRCC_OFS_STATUS) begin
			next_st.status[`TMRCC_ST_OVF] = (st.status[`TMRCC_ST_OVF] && !st.statusCaught[`TMRCC_ST_OVF])
				|| overflow;
		end

		// register views
		ctrlView[`TMRCC_F_GRP] = st.latchGrouping;
		ctrlView[`TMRCC_F_LEN] = st.counterLength;
		ctrlView[`TMRCC_F_SRC] = st.clockSourceSelect;
		ctrlView[`TMRCC_F_DIV] = st.prescaleDivider;
		ctrlView[`TMRCC_F_MODE] = st.countMode;
		ctrlView[`TMRCC_B_CLR] = 1'b0;
		ctrlView[`TMRCC_B_IE] = st.overflowIrqEnable;
		ctrlView[`TMRCC_B_FLAG] = st.overflowIrqFlag;
		if (st.overflowIrqFlag && st.overflowIrqEnable) begin
			vectorView = `TMRCC_VEC_OVF;
		end

		// read capture in setup cycle
		if (setupRd) begin
			next_st.statusCaught = 1'b0;
			unique case (paddr)
				`TMRCC_OFS_CTRL: next_st.readData = {16'h0000, ctrlView};
				`TMRCC_OFS_COUNT: next_st.readData = {16'h0000, st.count};
				`TMRCC_OFS_STATUS: begin
					next_st.readData = {31'h0, st.status};
					next_st.statusCaught = st.status;
				end
				`TMRCC_OFS_MASK: next_st.readData = {31'h0, st.mask};
				`TMRCC_OFS_VECTOR: next_st.readData = {16'h0000, vectorView};
				default: next_st.readData = 32'h0000_0000;
			endcase
		end

		// compare latch grouping, registered one cycle
		next_st.latchUpdate = groupedEvent;
	end

	// ========================================
	// state register
	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ========================================
	// outputs
	assign prdata = st.readData;
	assign compareLatchUpdate = st.latchUpdate;
	assign countValue = st.count;
	assign countMode = st.countMode;
	assign countDown = st.countDown;
	assign overflowIrqRequest = st.overflowIrqFlag && st.overflowIrqEnable;
	assign interruptVector = (st.overflowIrqFlag && st.overflowIrqEnable) ? `TMRCC_VEC_OVF : `TMRCC_VEC_NONE;
	assign irq = |(st.status & st.mask);

endmodule // tmrcc_top

// *** sim/tmrcc_checker.sv ***
// Purpose: port assertions of the timer control and count block
// Assumes: APB writes land when psel and penable are high
// Notes: ctl mirrors the control bits written by software
module tmrcc_checker
	import tmrcc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic [6:0] latchLoadEvent,
	input wire logic [6:0] compareLatchUpdate,
	input wire logic [15:0] countValue,
	input wire logic [1:0] countMode,
	input wire logic countDown,
	input wire logic overflowIrqRequest,
	input wire logic [15:0] interruptVector,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic wr;
	logic [14:0] ctl;
	assign wr = psel && penable && pwrite;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			ctl <= 15'h0000;
		else if (wr && paddr == 8'h00)
			ctl <= pwdata[14:0];
	end
	// ====
	// assertions
	AST_HALT: assert property (countMode == 2'h0 && !wr |=> $stable(countValue))
		else $error("count moved while halted");
	AST_UP: assert property (countMode inside {2'h1, 2'h2} && !countDown && !wr
		|=> countValue >= $past(countValue) || countValue == 16'h0000) else $error("up count went down");
	AST_DOWN: assert property (countMode == 2'h3 && countDown && countValue != 16'h0000 && !wr
		|=> countValue <= $past(countValue)) else $error("down count went up");
	AST_WCNT: assert property (wr && paddr == 8'h04 |=> countValue == $past(pwdata[15:0]))
		else $error("count write lost");
	AST_CLR: assert property (wr && paddr == 8'h00 && pwdata[2] |=> countValue == 16'h0000 && !countDown)
		else $error("clear did not act");
	AST_IE: assert property (!ctl[1] |-> !overflowIrqRequest)
		else $error("request while disabled");
	AST_VEC: assert property (interruptVector == (overflowIrqRequest ? 16'h000E : 16'h0000))
		else $error("vector wrong");
	AST_GRP: assert property (ctl[14:13] == 2'h0 && !wr |=> compareLatchUpdate == $past(latchLoadEvent))
		else $error("latch update wrong");
	AST_PSLV: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
		else $error("unmapped access not refused");
	cover property (countMode == 2'h3 && countDown);
	cover property (irq);
	cover property (compareLatchUpdate == 7'h7F);
endmodule // tmrcc_checker

bind tmrcc_top tmrcc_checker tmrcc_checker_i (.*);

// *** sim/testbench.sv ***
// Purpose: self-checking bench of the timer control and count block
// Assumes: zero wait state APB, source ticks held two cycles
// Notes: read results are queued and compared by a monitor
module testbench
	import tmrcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic externalTimerClock = 1'b0, auxClock = 1'b0, subMainClock = 1'b0;
	logic pready, pslverr, countDown, overflowIrqRequest, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0001823B;
	logic [15:0] periodLatch = 16'h0, countValue, interruptVector;
	logic [6:0] latchLoadEvent = 7'h0, compareLatchUpdate;
	logic [1:0] countMode;
	logic [32:0] expQ[$];
	int nMismatch = 0, comparisons = 0;

	always #4 clk_sys = ~clk_sys;
	tmrcc_top tmrcc_top_i (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.externalTimerClock(externalTimerClock),
		.auxClock(auxClock),
		.subMainClock(subMainClock),
		.periodLatch(periodLatch),
		.latchLoadEvent(latchLoadEvent),
		.compareLatchUpdate(compareLatchUpdate),
		.countValue(countValue),
		.countMode(countMode),
		.countDown(countDown),
		.overflowIrqRequest(overflowIrqRequest),
		.interruptVector(interruptVector),
		.irq(irq)
	);

	// ====
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [6:0] grpMap(int g, int i);
		case (g)
			0: return 7'(1 << i);
			1: return i == 0 ? 7'h01 : i % 2 ? 7'(3 << i) : 7'h00;
			2: return i == 0 ? 7'h01 : i == 1 ? 7'h0E : i == 4 ? 7'h70 : 7'h00;
			default: return i == 1 ? 7'h7F : 7'h00;
		endcase
	endfunction
	task automatic conclude();
		$display("counts: %0d mismatches in %0d comparisons", nMismatch, comparisons);
		if (nMismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(logic [32:0] seen, logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nMismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
		int k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			expQ.push_back(e);
		@(posedge clk_sys) penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge clk_sys);
			k++;
		end
		if (k == 20) begin
			nMismatch++;
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic pulse(logic [1:0] s, int n);
		repeat (2 * n) begin
			logic [31:0] r;
			r = rnd();
			externalTimerClock <= (s == 2'h0 || s == 2'h3) ? ~externalTimerClock : r[0];
			auxClock <= s == 2'h1 ? ~auxClock : r[1];
			subMainClock <= s == 2'h2 ? ~subMainClock : r[2];
			repeat (2) @(posedge clk_sys);
		end
	endtask
	always @(posedge clk_sys) begin
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, expQ.pop_front());
	end

	// ====
	// scenarios
	initial begin
		logic [31:0] v;
		logic [15:0] mx;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		xfer(0, 8'h00, 0, 33'h0);
		xfer(0, 8'h14, 0, 33'h100000000);
		for (int s = 0; s < 4; s++)
			for (int d = 0; d < 4; d++) begin
				xfer(1, 8'h00, 32'h4, 0);
				xfer(1, 8'h00, 32'(s << 8 | d << 6 | 32'h20), 0);
				pulse(2'(s), 8);
				xfer(0, 8'h04, 0, 33'(8 >> d));
				xfer(0, 8'h00, 0, 33'(s << 8 | d << 6 | 32'h20));
			end
		v = {16'h0, rnd() >> 16};
		xfer(1, 8'h00, 32'h0, 0);
		xfer(1, 8'h04, v, 0);
		pulse(2'h0, 4);
		xfer(0, 8'h04, 0, 33'(v));
		periodLatch <= 16'h0005;
		xfer(1, 8'h00, 32'h4, 0);
		xfer(1, 8'h00, 32'h10, 0);
		pulse(2'h0, 7);
		xfer(0, 8'h04, 0, 33'h1);
		chk(33'({overflowIrqRequest, interruptVector}), 33'h0);
		xfer(0, 8'h00, 0, 33'h11);
		xfer(1, 8'h00, 32'h13, 0);
		chk(33'({overflowIrqRequest, interruptVector}), 33'h1000E);
		xfer(0, 8'h10, 0, 33'hE);
		chk(33'(irq), 33'h0);
		xfer(1, 8'h0C, 32'h1, 0);
		chk(33'(irq), 33'h1);
		xfer(0, 8'h0C, 0, 33'h1);
		xfer(0, 8'h08, 0, 33'h1);
		chk(33'(irq), 33'h0);
		xfer(0, 8'h08, 0, 33'h0);
		for (int l = 0; l < 3; l++) begin
			mx = l == 0 ? 16'hFFFF : l == 1 ? 16'h0FFF : 16'h03FF;
			xfer(1, 8'h00, 32'(l << 11 | 32'h20), 0);
			xfer(1, 8'h04, 32'(mx - 16'h1), 0);
			pulse(2'h0, 2);
			xfer(0, 8'h04, 0, 33'h0);
		end
		periodLatch <= 16'h0003;
		xfer(1, 8'h00, 32'h4, 0);
		xfer(1, 8'h00, 32'h30, 0);
		chk(33'(countMode), 33'h3);
		pulse(2'h0, 5);
		chk(33'({countDown, countValue}), 33'h10001);
		xfer(1, 8'h00, 32'hF4, 0);
		chk(33'({countDown, countValue}), 33'h0);
		xfer(0, 8'h00, 0, 33'h30);
		for (int g = 0; g < 4; g++) begin
			xfer(1, 8'h00, 32'(g << 13), 0);
			for (int i = 0; i < 7; i++) begin
				latchLoadEvent <= 7'(1 << i);
				@(posedge clk_sys) latchLoadEvent <= 7'h00;
				@(negedge clk_sys) chk(33'(compareLatchUpdate), 33'(grpMap(g, i)));
				@(posedge clk_sys);
			end
		end
		conclude();
	end
endmodule // testbench
